// [swl_pkg.sv]
// Shared constants for the serial wiper setting loader
package swl_pkg;
  localparam int          WORD_W       = 8;
  localparam int          FIFO_DEPTH   = 32;
  localparam logic [7:0]  WIPER_RESET  = 8'h80;
  localparam logic [7:0]  WIPER_ZERO_B = 8'h00;
  localparam logic [3:0]  BIT_CNT_RST  = 4'h0;
  localparam logic [3:0]  BIT_CNT_FULL = 4'h8;
  typedef enum logic [1:0] {
    SWL_IDLE  = 2'b00,
    SWL_LOAD  = 2'b01
  } swl_state_t;
endpackage

// [swl_stream_if.sv]
// Valid/ready word stream between the loader's modules
`timescale 1ns/1ps
interface swl_stream_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// [swl_fifo.sv]
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module swl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             do_wr;
  logic             do_rd;
  logic             empty;

  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// [swl_loader.sv]
// Serial wiper setting loader: shift register on the serial clock, synchronisers
// crossing into the system clock, FIFO and wiper setting register on clk
`timescale 1ns/1ps
// Contract
// - The port has three inputs, active-low select, serial clock and data, and no data output.
// - Words are eight bits, most significant bit first, assembled in that order.
// - While select is low, data is shifted in on each rising serial clock edge only.
// - On select release the shift register is copied to the wiper setting register.
// - With more than eight edges in a frame only the last eight bits are kept.
// - After power-on the wiper setting register holds midscale, code 0x80.
// - The wiper setting is an unsigned 8-bit tap code, 0x00 at the B end.
module swl_loader (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       serial_clk,
  input  wire logic       cs_n,
  input  wire logic       serial_data_in,
  output logic      [7:0] wiper_setting_register,
  output logic            wiper_at_b_end,
  output logic            frame_dropped
);
  // Serial clock domain
  logic [7:0] shift_reg;
  logic [7:0] next_shift_reg;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic       frame_tgl;
  logic       next_frame_tgl;
  logic [7:0] frame_word;
  logic [7:0] next_frame_word;

  // Frames shift on rising serial clock edges only
  always_comb begin
    next_shift_reg = shift_reg;
    next_bit_cnt   = bit_cnt;
    if (!cs_n) begin
      next_shift_reg = {shift_reg[6:0], serial_data_in};
      if (bit_cnt != swl_pkg::BIT_CNT_FULL) begin
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= '0;
      bit_cnt   <= swl_pkg::BIT_CNT_RST;
    end else begin
      shift_reg <= next_shift_reg;
      bit_cnt   <= next_bit_cnt;
    end
  end

  // Select release captures the word and flags a frame by a toggle
  always_comb begin
    next_frame_word = shift_reg;
    next_frame_tgl  = !frame_tgl;
  end

  always_ff @(posedge cs_n or negedge rstn) begin
    if (!rstn) begin
      frame_word <= '0;
      frame_tgl  <= 1'b0;
    end else begin
      frame_word <= next_frame_word;
      frame_tgl  <= next_frame_tgl;
    end
  end

  // System clock domain: toggle synchroniser plus one settling stage.
  // The word flips together with the toggle, so a word bit may go
  // metastable in its first stage; the event waits one extra cycle so
  // that the FIFO only ever takes a word loaded from a settled stage.
  logic       tgl_s1;
  logic       tgl_s2;
  logic       tgl_s3;
  logic       tgl_s4;
  logic       next_tgl_s1;
  logic       next_tgl_s2;
  logic       next_tgl_s3;
  logic       next_tgl_s4;
  logic [7:0] word_s1;
  logic [7:0] word_s2;
  logic       frame_evt;

  always_comb begin
    next_tgl_s1 = frame_tgl;
    next_tgl_s2 = tgl_s1;
    next_tgl_s3 = tgl_s2;
    next_tgl_s4 = tgl_s3;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      tgl_s4 <= 1'b0;
    end else begin
      tgl_s1 <= next_tgl_s1;
      tgl_s2 <= next_tgl_s2;
      tgl_s3 <= next_tgl_s3;
      tgl_s4 <= next_tgl_s4;
    end
  end

  // Each word bit passes its own two-stage synchroniser
  for (genvar gi = 0; gi < swl_pkg::WORD_W; gi++) begin : g_word_sync
    logic next_s1;
    logic next_s2;

    always_comb begin
      next_s1 = frame_word[gi];
      next_s2 = word_s1[gi];
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        word_s1[gi] <= 1'b0;
        word_s2[gi] <= 1'b0;
      end else begin
        word_s1[gi] <= next_s1;
        word_s2[gi] <= next_s2;
      end
    end
  end

  // Fires when word_s2 holds a copy of an already settled first stage
  assign frame_evt = tgl_s3 ^ tgl_s4;

  swl_stream_if fifo_in ();
  swl_stream_if fifo_out ();

  assign fifo_in.data  = word_s2;
  assign fifo_in.valid = frame_evt;

  swl_fifo #(
    .WIDTH (swl_pkg::WORD_W),
    .DEPTH (swl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_data   (fifo_in.data),
    .in_valid  (fifo_in.valid),
    .in_ready  (fifo_in.ready),
    .out_data  (fifo_out.data),
    .out_valid (fifo_out.valid),
    .out_ready (fifo_out.ready)
  );

  // Wiper update state machine; each loaded word holds at least two cycles
  swl_pkg::swl_state_t state;
  swl_pkg::swl_state_t next_state;
  logic [7:0]          next_wiper;
  logic                next_dropped;
  logic                next_at_b_end;

  assign fifo_out.ready = (state == swl_pkg::SWL_IDLE);

  always_comb begin
    next_state   = state;
    next_wiper   = wiper_setting_register;
    next_dropped = frame_dropped;
    if (frame_evt && !fifo_in.ready) begin
      next_dropped = 1'b1;
    end
    case (state)
      swl_pkg::SWL_IDLE: begin
        if (fifo_out.valid) begin
          next_wiper = fifo_out.data;
          next_state = swl_pkg::SWL_LOAD;
        end
      end
      swl_pkg::SWL_LOAD: begin
        next_state = swl_pkg::SWL_IDLE;
      end
      default: begin
        next_state = swl_pkg::SWL_IDLE;
      end
    endcase
    // Tap code 0x00 puts the wiper at the B end
    next_at_b_end = (next_wiper == swl_pkg::WIPER_ZERO_B);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state                  <= swl_pkg::SWL_IDLE;
      wiper_setting_register <= swl_pkg::WIPER_RESET;
      frame_dropped          <= 1'b0;
      wiper_at_b_end         <= 1'b0;
    end else begin
      state                  <= next_state;
      wiper_setting_register <= next_wiper;
      frame_dropped          <= next_dropped;
      wiper_at_b_end         <= next_at_b_end;
    end
  end

  // The B end flag is registered alongside the code, so both always agree

  // Only three serial inputs exist; nothing drives back to the host
endmodule

// [swl_loader_chk.sv]
// Port checker for the serial wiper setting loader
`timescale 1ns/1ps
module swl_loader_chk (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       serial_clk,
  input wire logic       cs_n,
  input wire logic       serial_data_in,
  input wire logic [7:0] wiper_setting_register,
  input wire logic       wiper_at_b_end,
  input wire logic       frame_dropped
);
  logic [7:0] sh;
  logic [7:0] lat;
  wire  [7:0] w = wiper_setting_register;
  // Reference word that each select release should load
  always_ff @(posedge serial_clk or negedge rstn)
    if (!rstn) sh <= 8'h00;
    else if (!cs_n) sh <= {sh[6:0], serial_data_in};
  always_ff @(posedge cs_n or negedge rstn)
    if (!rstn) lat <= 8'h00;
    else lat <= sh;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  b_end_a: assert property (wiper_at_b_end == (w == 8'h00))
    else $error("b end flag");
  reset_mid_a: assert property ($rose(rstn) |-> w == 8'h80)
    else $error("reset value");
  load_val_a: assert property ($rose(cs_n) |-> ##6 w == lat)
    else $error("loaded value");
  load_wait_a: assert property ($rose(cs_n) |=> $stable(w) [*2])
    else $error("early load");
  frame_hold_a: assert property (!cs_n [*6] |-> $stable(w))
    else $error("change in frame");
  idle_hold_a: assert property (cs_n [*8] |-> $stable(w))
    else $error("change when idle");
  load_src_a: assert property ($changed(w) |-> !$past(cs_n, 7))
    else $error("change without frame");
  drop_keep_a: assert property (frame_dropped |=> frame_dropped)
    else $error("drop flag cleared");
endmodule
bind swl_loader swl_loader_chk u_chk (.*);

// [swl_host.sv]
// Host serial master model for the loader's serial port
`timescale 1ns/1ps
module swl_host (
  output logic serial_clk,
  output logic cs_n,
  output logic serial_data_in
);
  initial {serial_clk, cs_n, serial_data_in} = 3'h2;
  // Clock rests low; data flips while clock is high to expose late sampling
  task automatic frame(input logic [15:0] b, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = b[i];
      #12 serial_clk = 1'b1;
      #12 serial_data_in = ~b[i];
      #12 serial_clk = 1'b0;
      #12;
    end
    cs_n = 1'b1;
    serial_data_in = ~serial_data_in;
  endtask
endmodule

// [tb_swl_loader.sv]
// Testbench for the serial wiper setting loader
`timescale 1ns/1ps
module tb_swl_loader;
  logic       clk;
  logic       rstn;
  logic       serial_clk;
  logic       cs_n;
  logic       serial_data_in;
  logic [7:0] wiper_setting_register;
  logic       wiper_at_b_end;
  logic       frame_dropped;
  int         n_mismatch;
  int         n_checks;
  wire  [9:0] st = {frame_dropped, wiper_at_b_end, wiper_setting_register};
  swl_host u_host (.*);
  swl_loader u_dut (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_reset();
    rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk(st, 10'h080);
    $display("reset test done");
  endtask
  task automatic t_load(input logic [15:0] b, input int n,
                        input logic [7:0] e);
    @(negedge clk) #3 u_host.frame(b, n);
    repeat (8) @(negedge clk);
    chk(st, {1'b0, e == 8'h00, e});
    $display("load test %h done", e);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    t_reset();
    t_load(16'h00A5, 8, 8'hA5);
    t_load(16'h0000, 8, 8'h00);
    t_load(16'h0F3C, 12, 8'h3C);
    t_load(16'h00FF, 8, 8'hFF);
    t_load(16'h0001, 3, 8'hF9);
    t_reset();
    t_load(16'h007F, 8, 8'h7F);
    wrap_up();
  end
endmodule
